// File: rtl/cma_pkg.sv
// Constants, types and register layout for the core memory addressing block.
// Assumes one core clock and an APB master for software visibility.
package cma_pkg;

  // ------------------------------------------------------------------
  // Memory geometry
  // ------------------------------------------------------------------
  localparam int STACK_DEPTH  = 16;
  localparam int PC_WIDTH     = 15;
  localparam int PROG_WIDTH   = 14;
  localparam int PROG_AW      = 11;
  localparam int BANK_COUNT   = 32;
  localparam int GPR_PER_BANK = 80;
  localparam int GPR_TOTAL    = BANK_COUNT * GPR_PER_BANK;
  localparam int COMMON_SIZE  = 16;
  localparam logic [PROG_AW-1:0] PROG_LAST = 11'h7ff;

  // ------------------------------------------------------------------
  // Bank offset map
  // ------------------------------------------------------------------
  localparam logic [6:0] OFS_INDIRECT0 = 7'h00;
  localparam logic [6:0] OFS_INDIRECT1 = 7'h01;
  localparam logic [6:0] OFS_PC_LOW    = 7'h02;
  localparam logic [6:0] OFS_STATUS    = 7'h03;
  localparam logic [6:0] OFS_PTR0_LOW  = 7'h04;
  localparam logic [6:0] OFS_PTR0_HIGH = 7'h05;
  localparam logic [6:0] OFS_PTR1_LOW  = 7'h06;
  localparam logic [6:0] OFS_PTR1_HIGH = 7'h07;
  localparam logic [6:0] OFS_BANK_SEL  = 7'h08;
  localparam logic [6:0] OFS_CORE_LAST = 7'h0b;
  localparam logic [6:0] OFS_GPR_FIRST = 7'h20;
  localparam logic [6:0] OFS_GPR_LAST  = 7'h6f;
  localparam logic [6:0] OFS_COMMON    = 7'h70;

  // Pointer decode: bit 15 selects program memory, below PTR_BANK_TOP is banked.
  localparam int          PTR_PROG_BIT  = 15;
  localparam logic [15:0] PTR_BANK_TOP  = 16'h1000;

  // ------------------------------------------------------------------
  // APB register offsets (byte addresses)
  // ------------------------------------------------------------------
  localparam logic [7:0] APB_STATUS  = 8'h00;
  localparam logic [7:0] APB_POWER   = 8'h04;
  localparam logic [7:0] APB_CONTROL = 8'h08;
  localparam logic [7:0] APB_BANK    = 8'h0c;
  localparam logic [7:0] APB_PTR0    = 8'h10;
  localparam logic [7:0] APB_PTR1    = 8'h14;
  localparam logic [7:0] APB_STACK   = 8'h18;

  // Power control bits and control bits.
  localparam int PWR_OVF_BIT  = 1;
  localparam int PWR_UNF_BIT  = 0;
  localparam int CTRL_RST_BIT = 0;

  // Reset values of the core status flags.
  localparam logic RST_TIMEOUT   = 1'b1;
  localparam logic RST_POWERDOWN = 1'b1;

  // ------------------------------------------------------------------
  // Types
  // ------------------------------------------------------------------
  typedef enum logic [1:0] {ALU_ADD, ALU_SUB, ALU_LOGIC} cma_alu_kind_t;

  typedef struct packed {
    logic [7:0] result;
    logic       zero;
    logic       digitCarry;
    logic       carry;
  } cma_alu_out_t;

  typedef struct packed {
    logic       timeout;
    logic       powerdown;
    logic       zero;
    logic       digitCarry;
    logic       carry;
  } cma_status_t;

endpackage

// File: rtl/cma_core_mem.sv
// Return stack, file pointers, banked data memory and core status flags.
// Assumes decode and ALU logic on the same clock drive the request ports,
// program memory answers combinationally on progWord, and APB reads state.
//
// Operation
// - Sixteen-entry fifteen-bit return stack, own storage.
// - Stack over/underflow sets flag, optional soft reset.
// - Two sixteen-bit pointers reach data and program.
// - Program-memory indirect access costs one extra cycle.
// - Fifteen-bit program counter, 14-bit program words.
// - Program addresses wrap inside implemented space.
// - Pointer bit fifteen selects program memory reads.
// - Indirect program read returns low eight bits.
// - Indirect writes to program memory are dropped.
// - Data memory is 32 banks of 128 bytes.
// - Bank holds core, special, general, common areas.
// - Bank select register steers direct accesses.
// - Unimplemented data locations read as zero.
// - Core registers sit at every bank's start.
// - Status as destination keeps ALU flag outcome.
// - Timeout and powerdown flags ignore writes.
// - Status bits seven to five read zero.
// - Timeout set by power-up, clear, sleep; cleared timeout.
// - Powerdown set by power-up, clear; cleared sleep.
// - Zero flag follows zero result.
// - Digit carry is carry out of bit three.
// - Carry out of bit seven; subtract adds complement.
//
// Implementation choices: the APB interface to the registers and the placing of the registers.
`timescale 1ns/1ps
module cma_core_mem
  import cma_pkg::*;
(
  // Clock and reset
  input  wire logic                  sys_clk,
  input  wire logic                  rst_n,
  // APB slave
  input  wire logic                  psel,
  input  wire logic                  penable,
  input  wire logic                  pwrite,
  input  wire logic [7:0]            paddr,
  input  wire logic [31:0]           pwdata,
  output logic                       pready,
  output logic [31:0]                prdata,
  output logic                       pslverr,
  // Return stack
  input  wire logic                  stackPush,
  input  wire logic                  stackPop,
  input  wire logic [PC_WIDTH-1:0]   stackPushData,
  output logic [PC_WIDTH-1:0]        stackTop,
  // Program counter and program memory
  input  wire logic                  pcLoad,
  input  wire logic [PC_WIDTH-1:0]   pcLoadValue,
  input  wire logic                  pcStep,
  output logic [PC_WIDTH-1:0]        pcValue,
  output logic [PROG_AW-1:0]         progAddr,
  input  wire logic [PROG_WIDTH-1:0] progWord,
  // Data memory access
  input  wire logic                  memReq,
  input  wire logic                  memWrite,
  input  wire logic [6:0]            memOffset,
  input  wire logic [7:0]            memWdata,
  output logic                       memBusy,
  output logic                       memValid,
  output logic [7:0]                 memRdata,
  // ALU flag update
  input  wire logic                  aluEn,
  input  wire cma_alu_kind_t         aluKind,
  input  wire logic [7:0]            aluA,
  input  wire logic [7:0]            aluB,
  output logic [7:0]                 aluResult,
  // Power events
  input  wire logic                  watchdogClear,
  input  wire logic                  sleepInstr,
  input  wire logic                  watchdogTimeout,
  output logic                       softReset,
  output logic [7:0]                 statusByte
);

  // ------------------------------------------------------------------
  // State
  // ------------------------------------------------------------------
  typedef struct packed {
    cma_status_t                              st;
    logic                                     overflow;
    logic                                     underflow;
    logic                                     resetEnable;
    logic [4:0]                               bank;
    logic [15:0]                              ptr0;
    logic [15:0]                              ptr1;
    logic [STACK_DEPTH-1:0][PC_WIDTH-1:0]     stack;
    logic [4:0]                               depth;
    logic [PC_WIDTH-1:0]                      pc;
    logic [PROG_AW-1:0]                       progAddr;
    logic                                     progPend;
    logic                                     rdValid;
    logic [7:0]                               rdData;
    logic [7:0]                               aluResult;
    logic                                     softReset;
    logic [31:0]                              apbData;
    logic                                     apbErr;
  } cma_state_t;

  cma_state_t s;
  cma_state_t next_s;

  logic [7:0] gprMem    [0:GPR_TOTAL-1];
  logic [7:0] commonMem [0:COMMON_SIZE-1];

  // ------------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------------
  // Subtraction adds the complement plus one, so a carry means no borrow.
  function automatic cma_alu_out_t aluCompute(cma_alu_kind_t k,
                                              logic [7:0] a,
                                              logic [7:0] b);
    logic [7:0] bb;
    logic [8:0] sum;
    logic [4:0] nib;
    cma_alu_out_t o;
    bb  = (k == ALU_SUB) ? ~b : b;
    sum = {1'b0, a} + {1'b0, bb} + {8'h00, (k == ALU_SUB)};
    nib = {1'b0, a[3:0]} + {1'b0, bb[3:0]} + {4'h0, (k == ALU_SUB)};
    o.result     = (k == ALU_LOGIC) ? (a & b) : sum[7:0];
    o.zero       = (o.result == 8'h00);
    o.digitCarry = nib[4];
    o.carry      = sum[8];
    return o;
  endfunction

  // Program addresses beyond the last word fold back into the array.
  function automatic logic [PROG_AW-1:0] progWrap(logic [PC_WIDTH-1:0] a);
    return a[PROG_AW-1:0] & PROG_LAST;
  endfunction

  // General RAM index for a bank and an offset inside its RAM window.
  function automatic int gprIndex(logic [4:0] bk, logic [6:0] ofs);
    return int'(bk) * GPR_PER_BANK + int'(ofs - OFS_GPR_FIRST);
  endfunction

  // ------------------------------------------------------------------
  // Address decode for the current data access
  // ------------------------------------------------------------------
  logic        isIndirect;
  logic [15:0] ptrSel;
  logic        toProg;
  logic        accValid;
  logic [4:0]  accBank;
  logic [6:0]  accOfs;
  logic        accBusy;

  // Indirect ports route through a pointer; direct uses the bank select.
  always_comb
  begin
    isIndirect = (memOffset == OFS_INDIRECT0) ||
                 (memOffset == OFS_INDIRECT1);
    ptrSel   = (memOffset == OFS_INDIRECT1) ? s.ptr1 : s.ptr0;
    toProg   = isIndirect && ptrSel[PTR_PROG_BIT];
    accValid = !isIndirect || (ptrSel < PTR_BANK_TOP);
    accBank  = isIndirect ? ptrSel[11:7] : s.bank;
    accOfs   = isIndirect ? ptrSel[6:0] : memOffset;
    accBusy  = s.progPend;
  end

  // Core registers answer at their offset whatever bank is selected.
  // An indirect port aimed at another indirect port reads zero.
  function automatic logic [7:0] readByte(cma_state_t q, logic [4:0] bk,
                                          logic [6:0] ofs, logic ok);
    logic [7:0] v;
    v = 8'h00;
    if (ok)
    begin
      unique case (1'b1)
        (ofs == OFS_PC_LOW):    v = q.pc[7:0];
        (ofs == OFS_STATUS):    v = {3'b000, q.st};
        (ofs == OFS_PTR0_LOW):  v = q.ptr0[7:0];
        (ofs == OFS_PTR0_HIGH): v = q.ptr0[15:8];
        (ofs == OFS_PTR1_LOW):  v = q.ptr1[7:0];
        (ofs == OFS_PTR1_HIGH): v = q.ptr1[15:8];
        (ofs == OFS_BANK_SEL):  v = {3'b000, q.bank};
        (ofs >= OFS_GPR_FIRST && ofs <= OFS_GPR_LAST):
          v = gprMem[gprIndex(bk, ofs)];
        (ofs >= OFS_COMMON):    v = commonMem[ofs[3:0]];
        default:                v = 8'h00;
      endcase
    end
    return v;
  endfunction

  // ------------------------------------------------------------------
  // Next state
  // ------------------------------------------------------------------
  cma_alu_out_t alu;
  logic         reqTaken;
  logic         wrTaken;
  logic         pushOk;
  logic         popOk;
  logic         apbSetup;
  logic         apbAccess;

  always_comb
  begin
    next_s   = s;
    alu      = aluCompute(aluKind, aluA, aluB);
    reqTaken = memReq && !accBusy;
    wrTaken  = reqTaken && memWrite && !toProg;
    pushOk   = stackPush && (s.depth < 5'(STACK_DEPTH));
    popOk    = stackPop && (s.depth != 5'h00);
    apbSetup = psel && !penable;
    apbAccess = psel && penable;
    next_s.softReset = 1'b0;
    next_s.rdValid   = 1'b0;

    // Return stack; a full push or empty pop raises a sticky flag.
    // A push that fits wins over a same-cycle pop; any push keeps that pop from underflow.
    if (pushOk)
    begin
      next_s.stack[s.depth[3:0]] = stackPushData;
      next_s.depth = s.depth + 5'h01;
    end
    else if (popOk)
      next_s.depth = s.depth - 5'h01;
    if (stackPush && !pushOk)
      next_s.overflow = 1'b1;
    if (stackPop && !stackPush && !popOk)
      next_s.underflow = 1'b1;
    next_s.softReset = ((stackPush && !pushOk) ||
                        (stackPop && !stackPush && !popOk)) &&
                       s.resetEnable;

    // Program counter, fifteen bits wide.
    if (pcLoad)
      next_s.pc = pcLoadValue;
    else if (pcStep)
      next_s.pc = s.pc + 15'h0001;
    next_s.progAddr = progWrap(next_s.pc);

    // Program word read: address now, low byte taken a cycle later.
    if (s.progPend)
    begin
      next_s.progPend = 1'b0;
      next_s.rdValid  = 1'b1;
      next_s.rdData   = progWord[7:0];
    end
    if (reqTaken && !memWrite && toProg)
    begin
      next_s.progPend = 1'b1;
      next_s.progAddr = progWrap(ptrSel[PC_WIDTH-1:0]);
    end
    else if (reqTaken && !memWrite)
    begin
      next_s.rdValid = 1'b1;
      next_s.rdData  = readByte(s, accBank, accOfs, accValid);
    end

    // Direct and indirect writes into core registers.
    if (wrTaken && accValid)
    begin
      unique case (1'b1)
        (accOfs == OFS_STATUS):
          if (!aluEn)
            {next_s.st.zero, next_s.st.digitCarry, next_s.st.carry}
              = memWdata[2:0];
        (accOfs == OFS_PTR0_LOW):  next_s.ptr0[7:0]  = memWdata;
        (accOfs == OFS_PTR0_HIGH): next_s.ptr0[15:8] = memWdata;
        (accOfs == OFS_PTR1_LOW):  next_s.ptr1[7:0]  = memWdata;
        (accOfs == OFS_PTR1_HIGH): next_s.ptr1[15:8] = memWdata;
        (accOfs == OFS_BANK_SEL):  next_s.bank = memWdata[4:0];
        default: ;
      endcase
    end

    // ALU outcome; logic operations leave both carries alone.
    if (aluEn)
    begin
      next_s.aluResult = alu.result;
      next_s.st.zero   = alu.zero;
      if (aluKind != ALU_LOGIC)
      begin
        next_s.st.digitCarry = alu.digitCarry;
        next_s.st.carry      = alu.carry;
      end
    end

    // Power events; a watchdog time-out outranks a clear instruction.
    if (watchdogClear)
    begin
      next_s.st.timeout   = 1'b1;
      next_s.st.powerdown = 1'b1;
    end
    if (sleepInstr)
    begin
      next_s.st.timeout   = 1'b1;
      next_s.st.powerdown = 1'b0;
    end
    if (watchdogTimeout)
      next_s.st.timeout = 1'b0;

    // APB: data latched in setup; write-one clears lose to a new event.
    if (apbSetup)
    begin
      next_s.apbErr  = 1'b0;
      next_s.apbData = 32'h0000_0000;
      unique case (paddr)
        APB_STATUS:  next_s.apbData[7:0] = {3'b000, s.st};
        APB_POWER:   next_s.apbData[1:0] = {s.overflow, s.underflow};
        APB_CONTROL: next_s.apbData[0]   = s.resetEnable;
        APB_BANK:    next_s.apbData[4:0] = s.bank;
        APB_PTR0:    next_s.apbData[15:0] = s.ptr0;
        APB_PTR1:    next_s.apbData[15:0] = s.ptr1;
        APB_STACK:   next_s.apbData[4:0] = s.depth;
        default:     next_s.apbErr = 1'b1;
      endcase
    end

    // Writes land at the access edge, where pready is seen high.
    if (apbAccess && pwrite && paddr == APB_CONTROL)
      next_s.resetEnable = pwdata[CTRL_RST_BIT];
    if (apbAccess && pwrite && paddr == APB_POWER)
    begin
      if (pwdata[PWR_OVF_BIT] && !(stackPush && !pushOk))
        next_s.overflow = 1'b0;
      if (pwdata[PWR_UNF_BIT] && !(stackPop && !stackPush && !popOk))
        next_s.underflow = 1'b0;
    end
  end

  // ------------------------------------------------------------------
  // Registers
  // ------------------------------------------------------------------
  // Power-up values: timeout and powerdown set, stack empty.
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      s              <= '0;
      s.st.timeout   <= RST_TIMEOUT;
      s.st.powerdown <= RST_POWERDOWN;
    end
    else
      s <= next_s;
  end

  // RAM arrays keep no reset; contents after power-up are undefined.
  always_ff @(posedge sys_clk)
  begin
    if (wrTaken && accValid)
    begin
      if (accOfs >= OFS_GPR_FIRST && accOfs <= OFS_GPR_LAST)
        gprMem[gprIndex(accBank, accOfs)] <= memWdata;
      else if (accOfs >= OFS_COMMON)
        commonMem[accOfs[3:0]] <= memWdata;
    end
  end

  // ------------------------------------------------------------------
  // Outputs
  // ------------------------------------------------------------------
  assign pready     = 1'b1;
  assign prdata     = s.apbData;
  assign pslverr    = s.apbErr && psel && penable;
  assign stackTop   = (s.depth == 5'h00) ? '0
                                         : s.stack[4'(s.depth - 5'h01)];
  assign pcValue    = s.pc;
  assign progAddr   = s.progAddr;
  assign memBusy    = s.progPend;
  assign memValid   = s.rdValid;
  assign memRdata   = s.rdData;
  assign aluResult  = s.aluResult;
  assign softReset  = s.softReset;
  assign statusByte = {3'b000, s.st};

  // ------------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------------
  sequence s_progReq;
    memReq && !memWrite && !memBusy && toProg;
  endsequence
  sequence s_progAnswer;
    memBusy && !memValid ##1 memValid && !memBusy;
  endsequence

  property p_progExtra;
    @(posedge sys_clk) disable iff (!rst_n)
      s_progReq |=> s_progAnswer;
  endproperty
  a_progExtra: assert property (p_progExtra)
    else $error("Program read did not take two cycles.");

  property p_overflow;
    @(posedge sys_clk) disable iff (!rst_n)
      (stackPush && s.depth == 5'd16) |=> s.overflow;
  endproperty
  a_overflow: assert property (p_overflow)
    else $error("Full stack push did not set overflow.");

  property p_underflow;
    @(posedge sys_clk) disable iff (!rst_n)
      (stackPop && !stackPush && s.depth == 5'd0) |=> s.underflow;
  endproperty
  a_underflow: assert property (p_underflow)
    else $error("Empty stack pop did not set underflow.");

  property p_softReset;
    @(posedge sys_clk) disable iff (!rst_n)
      (stackPush && s.depth == 5'd16 && s.resetEnable)
        |=> softReset ##1 !softReset;
  endproperty
  a_softReset: assert property (p_softReset)
    else $error("Stack fault did not pulse soft reset.");

  property p_pcWrap;
    @(posedge sys_clk) disable iff (!rst_n)
      (pcLoad && !(memReq && !memWrite && !memBusy && toProg)) |=>
        progAddr == ($past(pcLoadValue[PROG_AW-1:0]) & PROG_LAST);
  endproperty
  a_pcWrap: assert property (p_pcWrap)
    else $error("Program address did not wrap.");

  property p_sleep;
    @(posedge sys_clk) disable iff (!rst_n)
      (sleepInstr && !watchdogTimeout) |=>
        !statusByte[3] && statusByte[4];
  endproperty
  a_sleep: assert property (p_sleep)
    else $error("Sleep did not set timeout and clear powerdown.");

  property p_flagsHeld;
    @(posedge sys_clk) disable iff (!rst_n)
      !(watchdogClear || sleepInstr || watchdogTimeout)
        |=> $stable(statusByte[4:3]);
  endproperty
  a_flagsHeld: assert property (p_flagsHeld)
    else $error("Timeout or powerdown changed without an event.");

  property p_zero;
    @(posedge sys_clk) disable iff (!rst_n)
      aluEn |=> statusByte[2] == (aluResult == 8'h00);
  endproperty
  a_zero: assert property (p_zero)
    else $error("Zero flag does not match result.");

  property p_bank;
    @(posedge sys_clk) disable iff (!rst_n)
      (wrTaken && !isIndirect && memOffset == OFS_BANK_SEL)
        |=> s.bank == $past(memWdata[4:0]);
  endproperty
  a_bank: assert property (p_bank)
    else $error("Bank select not updated by write.");

  property p_upperZero;
    @(posedge sys_clk) disable iff (!rst_n)
      statusByte[7:5] == 3'b000;
  endproperty
  a_upperZero: assert property (p_upperZero)
    else $error("Status upper bits not zero.");

endmodule // cma_core_mem

// File: tb/cma_prog_rom.sv
// Program memory model for the core memory block.
// Assumes the core reads progWord in the cycle it shows progAddr.
`timescale 1ns/1ps
module cma_prog_rom
  import cma_pkg::*;
(
  // Fetch port
  input  wire logic [PROG_AW-1:0] progAddr,
  output logic [PROG_WIDTH-1:0]   progWord
);
  // Contents follow the address, so a wrong fetch address shows.
  assign progWord = {3'h5, progAddr ^ 11'h2c3};
endmodule // cma_prog_rom

// File: tb/testbench.sv
// Self-checking bench for cma_core_mem through APB and its core ports.
// Assumes cma_pkg and cma_prog_rom are compiled before it.
`timescale 1ns/1ps
module testbench;
  import cma_pkg::*;
  logic sys_clk = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0;
  logic pcLoad = 0, pcStep = 0, memReq = 0, memWrite = 0, aluEn = 0;
  logic pready, pslverr, memBusy, memValid, softReset, sawErr, sawRst = 0;
  logic [4:0] ev = 0;
  logic [6:0] memOffset = 0;
  logic [7:0] paddr = 0, memWdata = 0, aluA = 0, aluB = 0;
  logic [7:0] memRdata, aluResult, statusByte;
  logic [31:0] pwdata = 0, prdata, r;
  logic [PC_WIDTH-1:0] stackPushData = 0, pcLoadValue = 0, stackTop, pcValue;
  logic [PROG_AW-1:0] progAddr;
  logic [PROG_WIDTH-1:0] progWord;
  cma_alu_kind_t aluKind = ALU_ADD;
  int num_errors = 0, checks = 0, lat;
  cma_core_mem DUT (.sys_clk(sys_clk), .rst_n(rst_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .stackPush(ev[1]), .stackPop(ev[0]), .stackPushData(stackPushData),
    .stackTop(stackTop), .pcLoad(pcLoad), .pcLoadValue(pcLoadValue),
    .pcStep(pcStep), .pcValue(pcValue), .progAddr(progAddr),
    .progWord(progWord), .memReq(memReq), .memWrite(memWrite),
    .memOffset(memOffset), .memWdata(memWdata), .memBusy(memBusy),
    .memValid(memValid), .memRdata(memRdata), .aluEn(aluEn),
    .aluKind(aluKind), .aluA(aluA), .aluB(aluB), .aluResult(aluResult),
    .watchdogClear(ev[2]), .sleepInstr(ev[3]), .watchdogTimeout(ev[4]),
    .softReset(softReset), .statusByte(statusByte));
  cma_prog_rom ROM (.progAddr(progAddr), .progWord(progWord));
  // Clock, and a latch for the one-cycle soft reset pulse.
  always #10 sys_clk = ~sys_clk;
  always @(posedge sys_clk) if (softReset === 1'b1) sawRst <= 1;
  task automatic chk(input logic [63:0] g, e);
    checks++;
    if (g !== e)
    begin
      num_errors++;
      $display("unexpected at %0t: got %h want %h", $time, g, e);
    end
  endtask
  // APB master: request held until pready is seen with penable.
  task automatic apb(input logic w, logic [7:0] a, logic [31:0] d);
    @(posedge sys_clk);
    {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
    @(posedge sys_clk);
    penable <= 1;
    do @(posedge sys_clk); while (pready !== 1'b1);
    r = prdata;
    sawErr = pslverr;
    {psel, penable} <= 2'b00;
  endtask
  // Data access; reads count cycles until memValid.
  task automatic mem(input logic w, logic [6:0] o, logic [7:0] d);
    @(posedge sys_clk);
    {memReq, memWrite, memOffset, memWdata} <= {1'b1, w, o, d};
    @(posedge sys_clk);
    memReq <= 0;
    lat = 0;
    if (!w) do begin @(negedge sys_clk); lat++; end while (memValid !== 1);
    r = {24'h0, memRdata};
  endtask
  task automatic alu(input cma_alu_kind_t k, logic [7:0] a, b);
    @(posedge sys_clk);
    aluEn <= 1;
    aluKind <= k;
    {aluA, aluB} <= {a, b};
    @(posedge sys_clk);
    aluEn <= 0;
    @(negedge sys_clk);
  endtask
  // Event pulses: timeout, sleep, clear, push, pop.
  task automatic ctl(input logic [4:0] v, logic [14:0] d = 0);
    @(posedge sys_clk);
    {ev, stackPushData} <= {v, d};
    @(posedge sys_clk);
    ev <= 0;
    @(negedge sys_clk);
  endtask
  task automatic give_verdict();
    $display("checks %0d errors %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  initial
  begin
    repeat (8) @(posedge sys_clk);
    rst_n <= 1;
    apb(0, APB_STATUS, 0);
    chk(r, 32'h18);
    alu(ALU_ADD, 8'h0f, 8'h01);
    chk({aluResult, statusByte}, 16'h101a);
    alu(ALU_ADD, 8'hff, 8'h01);
    chk({aluResult, statusByte}, 16'h001f);
    alu(ALU_SUB, 8'h05, 8'h06);
    chk({aluResult, statusByte}, 16'hff18);
    alu(ALU_LOGIC, 8'hf0, 8'h0f);
    chk({aluResult, statusByte}, 16'h001c);
    mem(1, OFS_STATUS, 8'he2);
    mem(0, OFS_STATUS, 0);
    chk(r, 32'h1a);
    fork alu(ALU_ADD, 8'h01, 8'h01); mem(1, OFS_STATUS, 8'h07); join
    chk({aluResult, statusByte}, 16'h0218);
    ctl(5'h10);
    chk(statusByte[4:3], 2'b01);
    ctl(5'h08);
    chk(statusByte[4:3], 2'b10);
    ctl(5'h04);
    chk(statusByte[4:3], 2'b11);
    $display("test status done");
    apb(1, APB_CONTROL, 1);
    for (int i = 1; i <= STACK_DEPTH; i++) ctl(5'h02, PC_WIDTH'(i));
    chk(stackTop, 32'd16);
    apb(0, APB_STACK, 0);
    chk(r, 32'd16);
    ctl(5'h02, 15'h7fff);
    apb(0, APB_POWER, 0);
    chk({sawRst, r}, 33'h1_0000_0002);
    for (int i = 0; i <= STACK_DEPTH; i++) ctl(5'h01);
    apb(0, APB_POWER, 0);
    chk(r, 32'h3);
    apb(0, 8'h40, 0);
    chk({sawErr, r}, 33'h1_0000_0000);
    $display("test stack done");
    mem(1, OFS_PTR0_HIGH, 8'h8f);
    mem(1, OFS_PTR0_LOW, 8'hff);
    apb(0, APB_PTR0, 0);
    chk(r, 32'h8fff);
    mem(0, OFS_INDIRECT0, 0);
    chk({lat, r}, {32'd2, 32'h3c});
    mem(1, OFS_INDIRECT0, 8'h00);
    mem(0, OFS_INDIRECT0, 0);
    chk(r, 32'h3c);
    @(posedge sys_clk);
    {pcLoad, pcLoadValue} <= {1'b1, 15'h7ffe};
    @(posedge sys_clk);
    {pcLoad, pcStep} <= 2'b01;
    @(posedge sys_clk);
    pcStep <= 0;
    repeat (2) @(negedge sys_clk);
    chk({pcValue, progAddr}, {15'h7fff, 11'h7ff});
    $display("test program done");
    mem(1, OFS_BANK_SEL, 8'h03);
    mem(1, OFS_GPR_FIRST, 8'ha5);
    mem(1, OFS_COMMON, 8'hc3);
    mem(1, OFS_BANK_SEL, 8'h04);
    mem(1, OFS_GPR_FIRST, 8'h5a);
    mem(0, OFS_COMMON, 0);
    chk({lat, r}, {32'd1, 32'hc3});
    mem(0, OFS_BANK_SEL, 0);
    chk(r, 32'h04);
    mem(1, OFS_BANK_SEL, 8'h03);
    mem(0, OFS_GPR_FIRST, 0);
    chk(r, 32'ha5);
    mem(0, 7'h0c, 0);
    chk(r, 32'h0);
    apb(0, APB_BANK, 0);
    chk(r, 32'h3);
    $display("test bank done");
    give_verdict();
  end
  // Watchdog: the whole run needs far fewer cycles than this.
  initial
  begin
    #100us;
    num_errors++;
    give_verdict();
  end
endmodule // testbench
